// ==== design/npm_point_map.sv ====
// point map slave: decodes point accesses into monitor, command and parameter words
//
// Function
// - protocol active only when select equals 3
// - line rate 9600, baud code 2
// - run/stop/reference gated by command enable
// - station address frozen while drive runs
// - four point types: AI, BI, AO, BO
// - BI 4 returns status word bit 0
// - BI 6 returns status word bit 2
// - AO 15 code; AI 15 returns data
// - AO 16 code; AO 17 writes data
// - exactly one response per accepted request; none while busy or link inactive
// - 7-bit ASCII, 8-bit slots, one stop
`timescale 1ns/100ps
`include "npm_regs.svh"
module npm_point_map #(
  parameter int DW = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] chan_protocol_select,
  input wire logic [3:0] chan_baud_code,
  input wire logic link_command_enable,
  input wire logic [7:0] chan_station_addr,
  input wire logic drive_running,
  input wire logic req_valid,
  input wire npm_pkg::npm_point_type_t point_type_field,
  input wire logic [7:0] point_number_field,
  input wire logic req_write,
  input wire logic [DW-1:0] req_data,
  input wire logic [15:0] output_signal_status_word,
  input wire logic [DW-1:0] ai_monitor_data,
  input wire logic [DW-1:0] param_rd_data,
  input wire logic bo_cmd_value,
  output logic link_active,
  output logic [7:0] station_addr,
  output logic resp_valid,
  output logic resp_ack,
  output logic [DW-1:0] resp_data,
  output logic [4:0] mon_index,
  output logic [15:0] param_rd_code,
  output logic param_wr_strobe,
  output logic [15:0] param_wr_code,
  output logic [DW-1:0] param_wr_data,
  output logic cmd_strobe,
  output logic [7:0] cmd_point,
  output logic cmd_is_bit,
  output logic [DW-1:0] cmd_value,
  output logic [1:0] err_code
);
  import npm_pkg::*;

  npm_state_t state;
  logic mapped;
  logic is_run_cmd;
  logic bit_value;
  logic req_taken;
  logic wr_taken;
  logic cmd_blocked;

  // decode mapped points; reserved holes refused
  always_comb begin
    mapped = 1'b0;
    case (point_type_field)
      NPM_PT_AI: mapped = point_number_field >= `NPM_AI_FIRST && point_number_field <= `NPM_AI_LAST;
      NPM_PT_BI: mapped = point_number_field >= `NPM_BI_FIRST && point_number_field <= `NPM_BI_LAST
                          && point_number_field != `NPM_BI_RSV_A && point_number_field != `NPM_BI_RSV_B;
      NPM_PT_AO: mapped = point_number_field >= `NPM_AO_FIRST && point_number_field <= `NPM_AO_LAST
                          && !(point_number_field >= `NPM_AO_RSV_LO && point_number_field <= `NPM_AO_RSV_HI);
      NPM_PT_BO: mapped = point_number_field >= `NPM_BO_FIRST && point_number_field <= `NPM_BO_LAST
                          && !(point_number_field >= `NPM_BO_RSV_LO && point_number_field <= `NPM_BO_RSV_HI);
      default: mapped = 1'b0;
    endcase
  end

  // reference frequency and run bits (bo 1,2) are drive commands
  always_comb begin
    is_run_cmd = 1'b0;
    if (point_type_field == NPM_PT_AO && point_number_field == `NPM_AO_REF_FREQ) begin
      is_run_cmd = 1'b1;
    end else if (point_type_field == NPM_PT_BO && point_number_field <= `NPM_BO_RUN_LAST) begin
      is_run_cmd = 1'b1;
    end
  end

  // bit input selection from status word
  always_comb begin
    bit_value = 1'b0;
    if (point_number_field == `NPM_BI_SPEED_REACHED) begin
      bit_value = output_signal_status_word[`NPM_BIT_SPEED_REACHED];
    end else if (point_number_field == `NPM_BI_READY) begin
      bit_value = output_signal_status_word[`NPM_BIT_READY];
    end
  end

  // request qualifiers shared by the sequencer and both write paths
  always_comb begin
    req_taken = 1'b0;
    wr_taken = 1'b0;
    cmd_blocked = 1'b0;
    // a busy sequencer ignores requests; the host waits for the answer first
    if (state == NPM_ST_IDLE && req_valid && link_active) begin
      req_taken = 1'b1;
      wr_taken = mapped && req_write;
      cmd_blocked = is_run_cmd && req_write && !link_command_enable;
    end
  end

  // link only talks with protocol 3 and baud code 2 (9600 fixed)
  always_ff @(posedge mclk) begin
    if (rst) begin
      link_active <= 1'b0;
    end else begin
      link_active <= chan_protocol_select == `NPM_PROTO_CODE && chan_baud_code == `NPM_BAUD_CODE;
    end
  end

  // address only follows the parameter while stopped
  always_ff @(posedge mclk) begin
    if (rst) begin
      station_addr <= 8'h00;
    end else if (!drive_running) begin
      station_addr <= chan_station_addr;
    end
  end

  // request sequencer: one response per accepted request; every mapped AI read waits two cycles for data
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= NPM_ST_IDLE;
      resp_valid <= 1'b0;
      resp_ack <= 1'b0;
      resp_data <= '0;
      err_code <= 2'h0;
      mon_index <= 5'h00;
    end else begin
      resp_valid <= 1'b0;
      case (state)
        NPM_ST_IDLE: begin
          // refusals answer at once, so the host never waits on a bad point
          if (req_taken) begin
            if (!mapped) begin
              resp_valid <= 1'b1;
              resp_ack <= 1'b0;
              err_code <= 2'h1;
            end else if (cmd_blocked) begin
              resp_valid <= 1'b1;
              resp_ack <= 1'b0;
              err_code <= 2'h2;
            end else if (point_type_field == NPM_PT_AI && !req_write) begin
              mon_index <= point_number_field[4:0]; // refused points leave the index alone
              state <= NPM_ST_PARAM;
            end else begin
              resp_valid <= 1'b1;
              resp_ack <= 1'b1;
              err_code <= 2'h0;
              resp_data <= point_type_field == NPM_PT_BI ? {{(DW-1){1'b0}}, bit_value} : '0;
            end
          end
        end
        NPM_ST_PARAM: begin
          // spare cycle: the drive side settles the word picked by mon_index
          state <= NPM_ST_RESP;
        end
        NPM_ST_RESP: begin
          resp_valid <= 1'b1;
          resp_ack <= 1'b1;
          err_code <= 2'h0;
          resp_data <= {3'h0, mon_index} == `NPM_AI_PARAM_DATA ? param_rd_data : ai_monitor_data;
          state <= NPM_ST_IDLE;
        end
        default: state <= NPM_ST_IDLE;
      endcase
    end
  end

  // indirect parameter code points and data write; unmapped points never reach here
  always_ff @(posedge mclk) begin
    if (rst) begin
      param_rd_code <= 16'h0000;
      param_wr_code <= 16'h0000;
      param_wr_data <= '0;
      param_wr_strobe <= 1'b0;
    end else begin
      param_wr_strobe <= 1'b0;
      if (wr_taken && point_type_field == NPM_PT_AO) begin
        if (point_number_field == `NPM_AO_CODE_RD) begin
          param_rd_code <= req_data[15:0];
        end else if (point_number_field == `NPM_AO_CODE_WR) begin
          param_wr_code <= req_data[15:0];
        end else if (point_number_field == `NPM_AO_DATA_WR) begin
          param_wr_data <= req_data;
          param_wr_strobe <= 1'b1;
        end
      end
    end
  end

  // other writable points go out as a command strobe, gated for drive commands
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_strobe <= 1'b0;
      cmd_point <= 8'h00;
      cmd_is_bit <= 1'b0;
      cmd_value <= '0;
    end else begin
      cmd_strobe <= 1'b0;
      // parameter code and data points travel on their own path instead
      if (wr_taken && !cmd_blocked && (point_type_field == NPM_PT_BO
          || (point_type_field == NPM_PT_AO && point_number_field < `NPM_AO_CODE_RD))) begin
        cmd_strobe <= 1'b1;
        cmd_point <= point_number_field;
        cmd_is_bit <= point_type_field == NPM_PT_BO;
        cmd_value <= point_type_field == NPM_PT_BO ? {{(DW-1){1'b0}}, bo_cmd_value} : req_data;
      end
    end
  end
endmodule // npm_point_map

// ==== design/npm_regs.svh ====
// constants for the point map slave: point numbers, bit positions, codes
`ifndef NPM_REGS_SVH
`define NPM_REGS_SVH
`define NPM_PROTO_CODE 4'h3
`define NPM_BAUD_CODE 4'h2
`define NPM_LINE_RATE 9600
`define NPM_CHAR_DATA_BITS 7
`define NPM_CHAR_SLOT_BITS 8
`define NPM_AI_FIRST 8'h01
`define NPM_AI_LAST 8'h11
`define NPM_BI_FIRST 8'h01
`define NPM_BI_LAST 8'h12
`define NPM_BI_RSV_A 8'h07
`define NPM_BI_RSV_B 8'h08
`define NPM_BI_SPEED_REACHED 8'h04
`define NPM_BI_READY 8'h06
`define NPM_BIT_SPEED_REACHED 0
`define NPM_BIT_READY 2
`define NPM_AO_FIRST 8'h01
`define NPM_AO_LAST 8'h11
`define NPM_AO_RSV_LO 8'h03
`define NPM_AO_RSV_HI 8'h06
`define NPM_AO_REF_FREQ 8'h01
`define NPM_AO_CODE_RD 8'h0F
`define NPM_AO_CODE_WR 8'h10
`define NPM_AO_DATA_WR 8'h11
`define NPM_AI_PARAM_DATA 8'h0F
`define NPM_BO_FIRST 8'h01
`define NPM_BO_LAST 8'h14
`define NPM_BO_RSV_LO 8'h0A
`define NPM_BO_RSV_HI 8'h0C
`define NPM_BO_RUN_LAST 8'h02
`endif

// ==== design/npm_pkg.sv ====
// types for the point map slave
package npm_pkg;
  typedef enum logic [1:0] {
    NPM_PT_AI = 2'h0,
    NPM_PT_BI = 2'h1,
    NPM_PT_AO = 2'h2,
    NPM_PT_BO = 2'h3
  } npm_point_type_t;
  typedef enum logic [2:0] {
    NPM_ST_IDLE = 3'b001,
    NPM_ST_PARAM = 3'b010,
    NPM_ST_RESP = 3'b100
  } npm_state_t;
endpackage

// ==== dv/npm_drive_model.sv ====
// drive-side model: monitor words and parameter read word
`timescale 1ns/100ps
module npm_drive_model (
  input wire logic [4:0] mon_index,
  input wire logic [15:0] param_rd_code,
  output logic [31:0] ai_monitor_data,
  output logic [31:0] param_rd_data
);
  // index folded into the monitor word, read code into the parameter word, so a wrong selection shows
  assign ai_monitor_data = {27'h5A5A5A5, mon_index};
  assign param_rd_data = {16'hC0DE, param_rd_code};
endmodule // npm_drive_model

// ==== dv/npm_checker.sv ====
// port assertions for the point map slave
`timescale 1ns/100ps
module npm_checker #(
  parameter int DW = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] chan_protocol_select,
  input wire logic [3:0] chan_baud_code,
  input wire logic link_command_enable,
  input wire logic req_valid,
  input wire npm_pkg::npm_point_type_t point_type_field,
  input wire logic [7:0] point_number_field,
  input wire logic req_write,
  input wire logic [15:0] output_signal_status_word,
  input wire logic link_active,
  input wire logic resp_valid,
  input wire logic resp_ack,
  input wire logic [DW-1:0] resp_data,
  input wire logic param_wr_strobe,
  input wire logic cmd_strobe,
  input wire logic [1:0] err_code
);
  import npm_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // taken requests, assuming the host keeps to one outstanding request
  wire logic tk = req_valid && link_active;
  wire logic ai_rd = tk && point_type_field == NPM_PT_AI && !req_write && point_number_field inside {[8'h01:8'h11]};
  wire logic bi = tk && point_type_field == NPM_PT_BI;
  wire logic aow = tk && point_type_field == NPM_PT_AO && req_write;
  property p_link; !$past(rst) |-> link_active == $past(chan_protocol_select == 4'h3 && chan_baud_code == 4'h2); endproperty
  a_link: assert property (p_link) else $error("link state");
  property p_one; tk && !ai_rd |=> resp_valid; endproperty
  a_one: assert property (p_one) else $error("no answer");
  property p_ai; ai_rd |=> !resp_valid ##1 !resp_valid ##1 resp_valid; endproperty
  a_ai: assert property (p_ai) else $error("read answer time");
  property p_bi4; bi && point_number_field == 8'h04 |=> resp_data[0] == $past(output_signal_status_word[0]); endproperty
  a_bi4: assert property (p_bi4) else $error("speed bit");
  property p_bi6; bi && point_number_field == 8'h06 |=> resp_data[0] == $past(output_signal_status_word[2]); endproperty
  a_bi6: assert property (p_bi6) else $error("ready bit");
  property p_rsv; bi && point_number_field inside {8'h07, 8'h08} |=> !resp_ack && err_code == 2'h1; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved point");
  property p_cmd; aow && point_number_field == 8'h01 && !link_command_enable |=> !cmd_strobe && err_code == 2'h2; endproperty
  a_cmd: assert property (p_cmd) else $error("command gate");
  property p_wr; aow && point_number_field == 8'h11 |=> param_wr_strobe && resp_ack; endproperty
  a_wr: assert property (p_wr) else $error("param write");
  c_ai: cover property (ai_rd);
  c_wr: cover property (param_wr_strobe);
  c_cmd: cover property (cmd_strobe);
endmodule // npm_checker
bind npm_point_map npm_checker #(.DW(DW)) u_chk (.*);

// ==== dv/tb.sv ====
// self-checking bench for the point map slave
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("FAIL t=%0t %h %h", $time, a, b); end end
module tb;
  import npm_pkg::*;
  logic mclk = 1'h0, rst = 1'h1, link_command_enable = 1'h1, drive_running = 1'h0;
  logic req_valid = 1'h0, req_write = 1'h0, bo_cmd_value = 1'h0;
  logic [3:0] chan_protocol_select = 4'h3, chan_baud_code = 4'h2;
  logic [7:0] chan_station_addr = 8'h21, point_number_field = 8'h00, station_addr, cmd_point;
  logic [15:0] output_signal_status_word = 16'h0000, param_rd_code, param_wr_code;
  logic [31:0] req_data = 32'h0, ai_monitor_data, param_rd_data, resp_data, param_wr_data, cmd_value;
  npm_point_type_t point_type_field = NPM_PT_AI;
  logic link_active, resp_valid, resp_ack, param_wr_strobe, cmd_strobe, cmd_is_bit, g_ack, g_pw, g_cs;
  logic [4:0] mon_index;
  logic [1:0] err_code, g_err;
  int bad_count = 0, n_tests = 0;
  // rows: type, point, write, ack, error code
  logic [13:0] rows [14] = '{14'h0014, 14'h0114, 14'h0121, 14'h0001, 14'h1124, 14'h1071, 14'h1131,
    14'h202C, 14'h2039, 14'h2069, 14'h2129, 14'h30C9, 14'h314C, 14'h3159};
  always #12.5 mclk = ~mclk;
  npm_point_map dut (.*);
  npm_drive_model drv (.*);
  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one request pulse, then a bounded wait for the answer
  task automatic req(input npm_point_type_t t, input logic [7:0] n, input logic w, input logic [31:0] d);
    point_type_field = t;
    {point_number_field, req_write, req_data, bo_cmd_value, req_valid} = {n, w, d, d[0], 1'h1};
    @(posedge mclk) #1;
    {req_valid, g_pw, g_cs} = {1'h0, param_wr_strobe, cmd_strobe};
    repeat (4) if (resp_valid !== 1'h1) @(posedge mclk) #1;
    if (resp_valid !== 1'h1) begin
      bad_count++;
      close_out();
    end
    {g_ack, g_err} = {resp_ack, err_code};
    // one idle edge so req_valid never falls and rises in the same step
    @(posedge mclk) #1;
  endtask
  initial begin
    repeat (16) @(posedge mclk) #1;
    `CHK({link_active, resp_valid, station_addr}, 10'h000)
    rst = 1'h0;
    repeat (2) @(posedge mclk) #1;
    foreach (rows[k]) begin
      req(npm_point_type_t'(rows[k][13:12]), rows[k][11:4], rows[k][3], 32'h0);
      `CHK({g_ack, g_err}, rows[k][2:0])
    end
    req(NPM_PT_AI, 8'h02, 1'h0, 32'h0);
    `CHK(resp_data, {27'h5A5A5A5, 5'h02})
    req(NPM_PT_AI, 8'h00, 1'h0, 32'h0);
    `CHK(mon_index, 5'h02)
    for (int s = 0; s < 2; s++) begin
      output_signal_status_word = s ? 16'hFFFE : 16'h0001;
      req(NPM_PT_BI, 8'h04, 1'h0, 32'h0);
      `CHK(resp_data[0], 1'(s == 0))
      output_signal_status_word = s ? 16'h0004 : 16'hFFFB;
      req(NPM_PT_BI, 8'h06, 1'h0, 32'h0);
      `CHK(resp_data[0], 1'(s == 1))
    end
    req(NPM_PT_AO, 8'h0F, 1'h1, 32'hFFFF1234);
    req(NPM_PT_AI, 8'h0F, 1'h0, 32'h0);
    `CHK(resp_data, 32'hC0DE1234)
    req(NPM_PT_AO, 8'h10, 1'h1, 32'h0000FFFF);
    req(NPM_PT_AO, 8'h11, 1'h1, 32'h3F800000);
    `CHK({g_pw, param_wr_code, param_wr_data}, {1'h1, 16'hFFFF, 32'h3F800000})
    link_command_enable = 1'h0;
    req(NPM_PT_BO, 8'h02, 1'h1, 32'h1);
    `CHK({g_cs, g_ack, g_err}, 4'h2)
    req(NPM_PT_AO, 8'h01, 1'h1, 32'h1388);
    `CHK({g_cs, g_ack, g_err}, 4'h2)
    link_command_enable = 1'h1;
    req(NPM_PT_AO, 8'h01, 1'h1, 32'h1388);
    `CHK({g_cs, g_ack}, 2'h3)
    `CHK({cmd_point, cmd_is_bit, cmd_value}, {8'h01, 1'h0, 32'h1388})
    req(NPM_PT_BO, 8'h01, 1'h1, 32'h1);
    `CHK({g_cs, g_ack, cmd_point, cmd_is_bit, cmd_value}, {2'h3, 8'h01, 1'h1, 32'h1})
    {drive_running, chan_station_addr} = {1'h1, 8'h5E};
    repeat (3) @(posedge mclk) #1;
    `CHK(station_addr, 8'h21)
    drive_running = 1'h0;
    repeat (3) @(posedge mclk) #1;
    `CHK(station_addr, 8'h5E)
    {chan_protocol_select, chan_baud_code} = 8'h42;
    repeat (2) @(posedge mclk) #1;
    `CHK(link_active, 1'h0)
    close_out();
  end
endmodule // tb
